//--- pwc_consts.svh
// pwc_consts.svh: offsets, field positions, flag bits, pin assignment and timing for the wake controller
// assumes: included by bare name wherever these macros are needed
`ifndef PWC_CONSTS_SVH
`define PWC_CONSTS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PWC_CLK_MHZ 250
`define PWC_PULSE_SHORT_US 10
`define PWC_PULSE_LONG_US 100

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PWC_ADDR_W 12
`define PWC_REG_DIR 12'h000
`define PWC_REG_OUT 12'h004
`define PWC_REG_WAKE 12'h008
`define PWC_REG_STATUS 12'h00C

// ----------------------------------------
// register fields
// ----------------------------------------
`define PWC_WAKE_POL_LSB 16
`define PWC_STS_READY 0
`define PWC_STS_PHYEXT 1
`define PWC_STS_PIN_LSB 16

// ----------------------------------------
// eeprom wake flag bit positions
// ----------------------------------------
`define PWC_FLG_WAKE_EN 0
`define PWC_FLG_PULSE 1
`define PWC_FLG_LENGTH 2
`define PWC_FLG_POLARITY 3
`define PWC_FLG_PUSHPULL 4
`define PWC_FLG_WOL_SEL 5
`define PWC_FLG_G10_DET 6
`define PWC_FLG_POWER 7

// ----------------------------------------
// pin assignment
// ----------------------------------------
`define PWC_NPIN 11
`define PWC_PIN_WAKE_INT 0
`define PWC_PIN_SEL_INT 1
`define PWC_PIN_WAKE_EXT 8
`define PWC_PIN_SEL_EXT 9
`define PWC_PIN_G10 10
`define PWC_FIRST_WAKE_INT 2

`endif

//--- pwc_pkg.sv
// pwc_pkg.sv: types for the wake controller
// assumes: pwc_consts.svh supplies all numeric constants
package pwc_pkg;

   // control sequence states
   typedef enum logic [0:0] {
      ST_LOAD,
      ST_RUN
   } pwc_state_t;

endpackage : pwc_pkg

//--- pwc_wake_controller.sv
// pwc_wake_controller.sv: wake-event signalling toward the embedded controller,
// gpio pin control and an apb register slave
// assumes: pins and eeprom loader are synchronous to clk; rst is power-on reset
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "pwc_consts.svh"

module pwc_wake_controller #(
   parameter int PULSE_SHORT_CYC = `PWC_PULSE_SHORT_US * `PWC_CLK_MHZ,
   parameter int PULSE_LONG_CYC = `PWC_PULSE_LONG_US * `PWC_CLK_MHZ
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic externalResetN,
   input wire logic phySelectStrap,
   input wire logic [`PWC_NPIN-1:0] gpioIn,
   output logic [`PWC_NPIN-1:0] gpioOut,
   output logic [`PWC_NPIN-1:0] gpioOe,
   input wire logic magicPacket,
   input wire logic wakeFrame,
   input wire logic linkUp,
   output logic eepromLoadReq,
   input wire logic eepromLoadDone,
   input wire logic eepromPresent,
   input wire logic [7:0] eepromFlags,
   input wire logic [`PWC_NPIN-1:0] eepromWakeMask,
   output logic deviceReady,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`PWC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   localparam int NP = `PWC_NPIN;

   // ----------------------------------------
   // state
   // ----------------------------------------
   pwc_pkg::pwc_state_t state, next_state;
   logic phyExt, next_phyExt;
   logic keepWake, next_keepWake;
   logic wakeMode, next_wakeMode;
   logic wakeActive, next_wakeActive;
   logic [23:0] pulseCnt, next_pulseCnt;
   logic [7:0] flags, next_flags;
   logic [NP-1:0] dir, next_dir;
   logic [NP-1:0] outReg, next_outReg;
   logic [NP-1:0] wakeEn, next_wakeEn;
   logic [NP-1:0] wakePol, next_wakePol;
   logic linkPrev, next_linkPrev;
   logic next_loadReq;
   logic next_ready;
   logic [NP-1:0] next_gpioOut, next_gpioOe;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;

   logic hwReset;
   logic wrEn;
   logic [NP-1:0] pinEvt;
   logic [NP-1:0] resvMask;
   logic netEvt, linkEvt, anyEvt;
   logic drvLevel;
   logic [3:0] wakePin, selPin;

   // external reset restarts the load like power-on, but wake mode and flags survive it
   assign hwReset = rst | ~externalResetN;
   assign wrEn = psel & penable & pready & pwrite;

   // ----------------------------------------
   // signalling pin choice
   // ----------------------------------------
   // pin roles follow the strapped phy mode
   assign wakePin = phyExt ? 4'(`PWC_PIN_WAKE_EXT) : 4'(`PWC_PIN_WAKE_INT);
   assign selPin = phyExt ? 4'(`PWC_PIN_SEL_EXT) : 4'(`PWC_PIN_SEL_INT);

   // ----------------------------------------
   // per-pin wake detect and pin drive
   // ----------------------------------------
   // wake level on the pin: polarity flag picks sense
   assign drvLevel = flags[`PWC_FLG_POLARITY] ? wakeActive : ~wakeActive;

   generate
      for (genvar i = 0; i < NP; i++) begin : g_pin
         logic usable;
         logic actLvl;
         logic isWake;
         logic isSel;
         // which pins may wake in each phy mode
         assign usable = phyExt ? (i == `PWC_PIN_G10) : (i >= `PWC_FIRST_WAKE_INT);
         // gpio10 sense from eeprom flag, others from polarity reg (0 = low)
         assign actLvl = (i == `PWC_PIN_G10) ? flags[`PWC_FLG_G10_DET] : wakePol[i];
         // input-only and enabled pins raise events
         assign pinEvt[i] = usable & wakeEn[i] & ~dir[i] & (gpioIn[i] == actLvl);
         assign isWake = wakeMode & (wakePin == 4'(i));
         assign isSel = wakeMode & (selPin == 4'(i));
         // signalling pins override register control in wake mode
         assign resvMask[i] = isWake | isSel;
         always_comb begin
            if (isWake) begin
               // push-pull drives both levels, open drain only pulls low
               next_gpioOe[i] = flags[`PWC_FLG_PUSHPULL] | ~drvLevel;
               next_gpioOut[i] = flags[`PWC_FLG_PUSHPULL] & drvLevel;
            end else if (isSel) begin
               next_gpioOe[i] = 1'b0;
               next_gpioOut[i] = 1'b0;
            end else begin
               next_gpioOe[i] = dir[i];
               next_gpioOut[i] = outReg[i];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // wake event sources
   // ----------------------------------------
   // network source: flag 0 magic packet, 1 wakeup frame
   assign netEvt = flags[`PWC_FLG_WOL_SEL] ? wakeFrame : magicPacket;
   assign linkEvt = linkUp & ~linkPrev;
   assign anyEvt = (|pinEvt) | netEvt | linkEvt;

   // ----------------------------------------
   // control next state
   // ----------------------------------------
   // reset, eeprom load, wake signalling and register writes
   always_comb begin
      next_state = state;
      next_phyExt = phyExt;
      next_keepWake = keepWake;
      next_wakeMode = wakeMode;
      next_wakeActive = wakeActive;
      next_pulseCnt = pulseCnt;
      next_flags = flags;
      next_dir = dir;
      next_outReg = outReg;
      next_wakeEn = wakeEn;
      next_wakePol = wakePol;
      next_linkPrev = linkUp;
      next_loadReq = 1'b0;
      next_ready = 1'b0;
      if (hwReset) begin
         next_state = pwc_pkg::ST_LOAD;
         next_phyExt = phySelectStrap;
         // sample mode-select while reset is held
         next_keepWake = phySelectStrap ? gpioIn[`PWC_PIN_SEL_EXT] : gpioIn[`PWC_PIN_SEL_INT];
         next_wakeActive = 1'b0;
         next_pulseCnt = '0;
         next_dir = '0;
         next_outReg = '0;
         next_wakePol = '0;
         next_linkPrev = 1'b0;
         next_loadReq = 1'b1;
         // power-on starts outside wake mode; pin roles kept over external reset
         if (rst) begin
            next_wakeMode = 1'b0;
            next_flags = '0;
         end
      end else begin
         case (state)
            pwc_pkg::ST_LOAD: begin
               next_loadReq = 1'b1;
               if (eepromLoadDone) begin
                  next_loadReq = 1'b0;
                  next_ready = 1'b1;
                  next_state = pwc_pkg::ST_RUN;
                  next_flags = eepromPresent ? eepromFlags : 8'h00;
                  next_wakeEn = eepromPresent ? eepromWakeMask : '0;
                  // wake mode: sample 1, eeprom present, enabled, self-powered
                  next_wakeMode = keepWake & eepromPresent
                     & eepromFlags[`PWC_FLG_WAKE_EN]
                     & eepromFlags[`PWC_FLG_POWER];
               end
            end
            pwc_pkg::ST_RUN: begin
               next_ready = 1'b1;
               // raise wake on any event; no status bit is touched
               if (wakeMode && !wakeActive && anyEvt) begin
                  next_wakeActive = 1'b1;
                  next_pulseCnt = flags[`PWC_FLG_LENGTH] ? 24'(PULSE_LONG_CYC)
                     : 24'(PULSE_SHORT_CYC);
               end else if (wakeActive && flags[`PWC_FLG_PULSE]) begin
                  // pulse mode ends by itself
                  if (pulseCnt <= 24'h000001) begin
                     next_wakeActive = 1'b0;
                  end else begin
                     next_pulseCnt = pulseCnt - 24'h000001;
                  end
               end
               // level mode: held until external reset
               // register writes; wake pins locked in wake mode
               if (wrEn) begin
                  case (paddr)
                     `PWC_REG_DIR: begin
                        next_dir = (pwdata[NP-1:0] & ~resvMask) | (dir & resvMask);
                     end
                     `PWC_REG_OUT: begin
                        next_outReg = (pwdata[NP-1:0] & ~resvMask) | (outReg & resvMask);
                     end
                     `PWC_REG_WAKE: begin
                        if (!wakeMode) begin
                           next_wakeEn = pwdata[NP-1:0];
                           next_wakePol = pwdata[`PWC_WAKE_POL_LSB +: NP];
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            default: begin
               next_state = pwc_pkg::ST_LOAD;
            end
         endcase
      end
   end

   // ----------------------------------------
   // apb slave next state
   // ----------------------------------------
   // one wait-free access: pready rises in the access phase
   always_comb begin
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = 32'h00000000;
      if (!rst && psel && !penable) begin
         next_pready = 1'b1;
         case (paddr)
            `PWC_REG_DIR: next_prdata[NP-1:0] = dir;
            `PWC_REG_OUT: next_prdata[NP-1:0] = outReg;
            `PWC_REG_WAKE: begin
               next_prdata[NP-1:0] = wakeEn;
               next_prdata[`PWC_WAKE_POL_LSB +: NP] = wakePol;
            end
            `PWC_REG_STATUS: begin
               // wake mode itself is never shown here
               next_prdata[`PWC_STS_READY] = deviceReady;
               next_prdata[`PWC_STS_PHYEXT] = phyExt;
               next_prdata[`PWC_STS_PIN_LSB +: NP] = gpioIn;
            end
            default: next_pslverr = 1'b1; // unmapped
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // control and pin state
   always_ff @(posedge clk) begin
      state <= next_state;
      phyExt <= next_phyExt;
      keepWake <= next_keepWake;
      wakeMode <= next_wakeMode;
      wakeActive <= next_wakeActive;
      pulseCnt <= next_pulseCnt;
      flags <= next_flags;
      dir <= next_dir;
      outReg <= next_outReg;
      wakeEn <= next_wakeEn;
      wakePol <= next_wakePol;
      linkPrev <= next_linkPrev;
      eepromLoadReq <= next_loadReq;
      deviceReady <= next_ready;
      if (rst) begin
         gpioOut <= '0;
         gpioOe <= '0;
      end else begin
         gpioOut <= next_gpioOut;
         gpioOe <= next_gpioOe;
      end
   end

   // bus answer
   always_ff @(posedge clk) begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
   end

endmodule : pwc_wake_controller

//--- pwc_wake_controller_asserts.sv
// port checker for the wake controller
// assumes: bound to pwc_wake_controller, one clock, rst synchronous
`timescale 1ns/1ns
module pwc_wake_controller_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic externalResetN,
   input wire logic phySelectStrap,
   input wire logic [10:0] gpioIn,
   input wire logic [10:0] gpioOut,
   input wire logic [10:0] gpioOe,
   input wire logic magicPacket,
   input wire logic eepromLoadReq,
   input wire logic eepromLoadDone,
   input wire logic eepromPresent,
   input wire logic [7:0] eepromFlags,
   input wire logic deviceReady,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   logic keepS, ext, wm, lvl, on0;
   // ---------------------------
   // mode tracking
   // ---------------------------
   // strap and mode-select seen in reset decide the mode at load
   always_ff @(posedge clk) begin
      if (rst || !externalResetN) begin
         keepS <= gpioIn[phySelectStrap ? 9 : 1];
         ext <= phySelectStrap;
      end
      if (rst) begin
         wm <= 1'h0;
      end else if (eepromLoadReq && eepromLoadDone) begin
         wm <= eepromPresent && eepromFlags[0] && eepromFlags[7] && keepS;
         lvl <= !eepromFlags[1] && eepromFlags[5:3] == 3'h3; // level, high, push-pull, magic
      end
   end
   assign on0 = wm && lvl && !ext;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_xrst_ready: assert property (!externalResetN |=> !deviceReady)
      else $error("ready high in external reset");
   chk_xrst_reload: assert property (!externalResetN |=> eepromLoadReq)
      else $error("no reload after external reset");
   chk_load_ready: assert property (
      eepromLoadDone && eepromLoadReq && externalResetN |=> deviceReady && !eepromLoadReq)
      else $error("not ready after load");
   chk_unmapped_err: assert property (
      psel && !penable && paddr > 12'h00C |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_magic_wake: assert property (
      on0 && deviceReady && externalResetN && magicPacket |-> ##2 gpioOut[0] && gpioOe[0])
      else $error("no wake after magic packet");
   chk_wake_hold: assert property (
      on0 && gpioOut[0] && externalResetN && $past(externalResetN) |=> gpioOut[0])
      else $error("level wake dropped early");
   chk_clear_pin: assert property (
      (on0 && !externalResetN) [*2] |=> !gpioOut[0] && gpioOe[0])
      else $error("wake not cleared by external reset");
   chk_int_pins: assert property (
      on0 && deviceReady && $past(deviceReady) |-> gpioOe[0] && !gpioOe[1])
      else $error("internal signalling pins wrong");
   chk_ext_pins: assert property (
      wm && lvl && ext && deviceReady && $past(deviceReady) |-> gpioOe[8] && !gpioOe[9])
      else $error("external signalling pins wrong");
endmodule : pwc_wake_controller_asserts

bind pwc_wake_controller pwc_wake_controller_asserts pwc_wake_controller_asserts_inst (
   .clk(clk), .rst(rst), .externalResetN(externalResetN), .phySelectStrap(phySelectStrap),
   .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .magicPacket(magicPacket),
   .eepromLoadReq(eepromLoadReq), .eepromLoadDone(eepromLoadDone),
   .eepromPresent(eepromPresent), .eepromFlags(eepromFlags), .deviceReady(deviceReady),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pslverr(pslverr)
);

//--- pwc_ec_model.sv
// embedded controller model: clearing reset and mode-select
// assumes: bench raises clearGo for one cycle after it has seen the wake
`timescale 1ns/1ns
module pwc_ec_model (
   input wire logic clk,
   input wire logic keepWake,
   input wire logic clearGo,
   output logic externalResetN,
   output logic modeSel
);
   logic [1:0] holdCnt;
   // quiet at time zero: reset released, asking to stay in wake mode
   initial begin
      externalResetN = 1'h1;
      modeSel = 1'h1;
      holdCnt = 2'h0;
   end
   // mode-select set with the reset and held all through it
   always @(posedge clk) begin
      modeSel <= keepWake;
      if (holdCnt != 2'h0) begin
         holdCnt <= holdCnt - 2'h1;
      end else if (clearGo) begin
         holdCnt <= 2'h3;
      end
      externalResetN <= holdCnt == 2'h0 && !clearGo;
   end
endmodule : pwc_ec_model

//--- testbench.sv
// self-checking bench for the wake controller
// assumes: bench plays eeprom loader, network and pins; pwc_ec_model the controller
`timescale 1ns/1ns
`include "pwc_consts.svh"
module testbench;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic phySelectStrap = 1'h0;
   logic magicPacket = 1'h0;
   logic linkUp = 1'h0;
   logic eepromLoadDone = 1'h0;
   logic [7:0] eepromFlags = 8'h99;
   logic [10:0] pinDrive = 11'h7FF;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic keepWake = 1'h1;
   logic clearGo = 1'h0;
   logic wakeFrame = 1'h0;
   logic externalResetN, modeSel, eepromLoadReq, deviceReady, pready, pslverr, err, wakeLevel;
   logic [10:0] pinIn, gpioOut, gpioOe;
   logic [31:0] prdata, rd;
   int n_errors = 0;
   int cmp_count = 0;
   always #2 clk = ~clk;
   // wire level: design where enabled, controller on mode-select, bench elsewhere
   assign pinIn = (gpioOe & gpioOut)
      | (~gpioOe & {pinDrive[10], modeSel, pinDrive[8:2], modeSel, pinDrive[0]});
   assign wakeLevel = pinIn[phySelectStrap ? 8 : 0];
   pwc_wake_controller #(.PULSE_SHORT_CYC(8), .PULSE_LONG_CYC(20)) pwc_wake_controller_inst (
      .clk(clk), .rst(rst), .externalResetN(externalResetN), .phySelectStrap(phySelectStrap),
      .gpioIn(pinIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .magicPacket(magicPacket),
      .wakeFrame(wakeFrame), .linkUp(linkUp), .eepromLoadReq(eepromLoadReq),
      .eepromLoadDone(eepromLoadDone), .eepromPresent(1'h1), .eepromFlags(eepromFlags),
      .eepromWakeMask(11'h404), .deviceReady(deviceReady), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   pwc_ec_model pwc_ec_model_inst (.clk(clk), .keepWake(keepWake), .clearGo(clearGo),
      .externalResetN(externalResetN), .modeSel(modeSel));
   // ---------------------------
   // shared tasks
   // ---------------------------
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : cmp
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      // a slave that never answers counts as a mismatch
      if (pready !== 1'h1) begin
         n_errors++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask : apb
   task automatic por(input logic ext);
      rst <= 1'h1;
      phySelectStrap <= ext;
      keepWake <= 1'h1;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
   endtask : por
   task automatic load(input logic [7:0] f);
      cmp("reload request", 32'h1, 32'(eepromLoadReq));
      cmp("ready in load", 32'h0, 32'(deviceReady));
      eepromFlags <= f;
      eepromLoadDone <= 1'h1;
      @(posedge clk);
      eepromLoadDone <= 1'h0;
      @(posedge clk);
      cmp("ready", 32'h1, 32'(deviceReady));
   endtask : load
   task automatic clear(input logic keep);
      keepWake <= keep;
      clearGo <= 1'h1;
      @(posedge clk);
      clearGo <= 1'h0;
      repeat (5) @(posedge clk);
      cmp("wake cleared", 32'h0, 32'(wakeLevel));
      load(8'h99);
   endtask : clear
   task automatic magic;
      magicPacket <= 1'h1;
      @(posedge clk);
      magicPacket <= 1'h0;
   endtask : magic
   task automatic see_wake(input logic exp);
      repeat (4) @(posedge clk);
      cmp("wake pin", 32'(exp), 32'(wakeLevel));
   endtask : see_wake
   // ---------------------------
   // scenarios
   // ---------------------------
   task automatic t_magic;
      por(1'h0);
      load(8'h99);
      see_wake(1'h0);
      magic;
      see_wake(1'h1);
      apb(1'h1, `PWC_REG_DIR, 32'h7FF);
      apb(1'h1, `PWC_REG_OUT, 32'h0);
      repeat (20) @(posedge clk);
      cmp("wake held", 32'h1, 32'(wakeLevel));
      cmp("signal pins oe", 32'h1, 32'(gpioOe[1:0]));
      clear(1'h1);
   endtask : t_magic
   task automatic t_link;
      linkUp <= 1'h1;
      see_wake(1'h1);
      clear(1'h1);
      linkUp <= 1'h0;
   endtask : t_link
   task automatic t_gpio;
      apb(1'h0, `PWC_REG_DIR, 32'h0);
      cmp("dir after reset", 32'h0, rd);
      apb(1'h1, `PWC_REG_DIR, 32'h4);
      pinDrive[2] <= 1'h0;
      see_wake(1'h0);
      apb(1'h1, `PWC_REG_DIR, 32'h0);
      see_wake(1'h1);
      clear(1'h0);
      pinDrive[2] <= 1'h1;
      magic;
      see_wake(1'h1);
      cmp("normal pin oe", 32'h0, 32'(gpioOe[0]));
   endtask : t_gpio
   task automatic t_apb;
      apb(1'h0, 12'h010, 32'h0);
      cmp("unmapped error", 32'h1, 32'(err));
      cmp("unmapped data", 32'h0, rd);
      apb(1'h0, `PWC_REG_STATUS, 32'h0);
      cmp("status ready", 32'h1, rd & 32'h3);
   endtask : t_apb
   task automatic t_no_mode;
      logic [15:0] fl;
      fl = 16'h1998;
      for (int i = 0; i < 2; i++) begin
         por(1'h0);
         load(fl[8*i +: 8]);
         magic;
         repeat (4) @(posedge clk);
         cmp("no mode oe", 32'h0, 32'(gpioOe[0]));
      end
   endtask : t_no_mode
   task automatic t_pulse;
      por(1'h0);
      load(8'hBB);
      magic;
      see_wake(1'h0);
      wakeFrame <= 1'h1;
      @(posedge clk);
      wakeFrame <= 1'h0;
      see_wake(1'h1);
      see_wake(1'h1);
      see_wake(1'h0);
   endtask : t_pulse
   task automatic t_ext;
      por(1'h1);
      load(8'h99);
      pinDrive[2] <= 1'h0;
      see_wake(1'h0);
      pinDrive[10] <= 1'h0;
      see_wake(1'h1);
      pinDrive <= 11'h7FF;
      clear(1'h1);
   endtask : t_ext
   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   // main sequence
   initial begin
      t_magic;
      t_link;
      t_gpio;
      t_apb;
      t_no_mode;
      t_pulse;
      t_ext;
      close_out;
   end
   // watchdog against a hang
   initial begin
      #20000;
      n_errors++;
      close_out;
   end
endmodule : testbench
